// ---- rtl/swr_pkg.sv ----
// package: shared types and timing constants for the supervisor watchdog and reset block
package swr_pkg;

  // ********************************************************
  // timing figures (as printed) and clock rate
  // ********************************************************
  localparam int SWR_CLK_HZ = 10_000_000;
  localparam int SWR_UPPER_US = 19000;        // upper bound, typical at nominal setting
  localparam int SWR_LOWER_US = 675;          // lower bound, typical at nominal setting
  localparam int SWR_RESET_US = 19000;        // reset timeout, typical at nominal setting
  localparam int SWR_UV_DELAY_US = 10;        // undervolt detect delay, least figure
  localparam int SWR_UPPER_CYC = SWR_UPPER_US * (SWR_CLK_HZ / 1_000_000);
  localparam int SWR_LOWER_CYC = SWR_LOWER_US * (SWR_CLK_HZ / 1_000_000);
  localparam int SWR_RESET_CYC = SWR_RESET_US * (SWR_CLK_HZ / 1_000_000);
  localparam int SWR_UV_CYC = SWR_UV_DELAY_US * (SWR_CLK_HZ / 1_000_000);
  localparam int SWR_CNT_W = 24;

  // ********************************************************
  // carriers
  // ********************************************************
  typedef struct packed {
    logic rise;
    logic fall;
  } swr_edges_t;

  typedef struct packed {
    logic watchdog_disable_in;
    logic timeout_mode;
    logic global_enable_lockout;
    logic output_good;
  } swr_ctrl_t;

  typedef enum logic [1:0] {
    SWR_WD_IDLE,
    SWR_WD_WATCH,
    SWR_WD_FAULT
  } swr_wd_state_t;

endpackage

// ---- rtl/swr_sync_edge.sv ----
// two-flop synchroniser with registered edge detector
`timescale 1ns/1ns
module swr_sync_edge
  import swr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic async_in,
  output logic level_out,
  output swr_edges_t edges
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // only sync_r reads the first stage; edges come from two later flops
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign edges.rise = sync_r & ~prev_r;
  assign edges.fall = ~sync_r & prev_r;

endmodule

// ---- rtl/swr_timer.sv ----
// up counter with clear, reports elapsed cycles
`timescale 1ns/1ns
module swr_timer
  import swr_pkg::*;
#(
  parameter int WIDTH = SWR_CNT_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clear,
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // saturate so a long stall never wraps into a false short interval
  assign count_nxt = clear ? '0 : ((&count_r) ? count_r : count_r + 1'b1);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

endmodule

// ---- rtl/swr_supervisor.sv ----
// supervisor: power-good reset generator and window/timeout watchdog
//
// Notes on behaviour
// - disable input stops checking, fault output high
// - window mode: early second fall faults
// - window mode: no fall by upper bound faults
// - timeout mode: any edge kicks, upper only
// - fault pulse lasts the reset timeout period
// - monitoring paused during fault, restarts fresh
// - reset held until good plus reset delay
// - upper and lower bounds set by separate parameters
// - reset delay programmable, but RESET_CYC also sets the fault pulse width
// - loss of good asserts reset after short delay
// - enable low holds all supervisory logic inactive
// - fault ends on timer expiry, reset assertion or watchdog disable
`timescale 1ns/1ns
module swr_supervisor
  import swr_pkg::*;
#(
  parameter int UPPER_CYC = SWR_UPPER_CYC,
  parameter int LOWER_CYC = SWR_LOWER_CYC,
  parameter int RESET_CYC = SWR_RESET_CYC,
  parameter int UV_CYC = SWR_UV_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic global_enable_lockout,
  input wire logic output_good,
  input wire logic watchdog_disable_in,
  input wire logic mode_timeout,
  input wire logic kick_input,
  output logic reset_out_n,
  output logic watchdog_fault_n
);

  // ********************************************************
  // input synchronisation
  // ********************************************************
  localparam logic [SWR_CNT_W-1:0] UPPER_N = SWR_CNT_W'(UPPER_CYC);
  localparam logic [SWR_CNT_W-1:0] LOWER_N = SWR_CNT_W'(LOWER_CYC);
  localparam logic [SWR_CNT_W-1:0] RESET_N = SWR_CNT_W'(RESET_CYC);
  localparam logic [SWR_CNT_W-1:0] UV_N = SWR_CNT_W'(UV_CYC);

  logic en_m_r, en_s_r, good_m_r, good_s_r, dis_m_r, dis_s_r, mode_m_r, mode_s_r;
  swr_ctrl_t ctrl;
  swr_edges_t kick_edges;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en_m_r <= 1'b0;
      en_s_r <= 1'b0;
      good_m_r <= 1'b0;
      good_s_r <= 1'b0;
      dis_m_r <= 1'b1;
      dis_s_r <= 1'b1;
      mode_m_r <= 1'b0;
      mode_s_r <= 1'b0;
    end else begin
      en_m_r <= global_enable_lockout;
      en_s_r <= en_m_r;
      good_m_r <= output_good;
      good_s_r <= good_m_r;
      dis_m_r <= watchdog_disable_in;
      dis_s_r <= dis_m_r;
      mode_m_r <= mode_timeout;
      mode_s_r <= mode_m_r;
    end
  end

  assign ctrl.global_enable_lockout = en_s_r;
  assign ctrl.output_good = good_s_r;
  assign ctrl.watchdog_disable_in = dis_s_r;
  assign ctrl.timeout_mode = mode_s_r;

  swr_sync_edge u_kick (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(kick_input),
    .level_out(),
    .edges(kick_edges)
  );

  // ********************************************************
  // power-good reset generator
  // ********************************************************
  typedef enum logic [1:0] {
    SWR_RST_HOLD,
    SWR_RST_DELAY,
    SWR_RST_RUN,
    SWR_RST_DETECT
  } swr_rst_state_t;

  swr_rst_state_t rst_state_r, rst_state_nxt;
  logic rst_clear;
  logic [SWR_CNT_W-1:0] rst_count;
  logic reset_out_n_r, reset_out_n_nxt;
  logic active;

  assign active = ctrl.global_enable_lockout;

  swr_timer u_rst_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(rst_clear),
    .count(rst_count)
  );

  always_comb begin
    rst_state_nxt = rst_state_r;
    rst_clear = 1'b1;
    unique case (rst_state_r)
      SWR_RST_HOLD: begin
        if (active && ctrl.output_good) begin
          rst_state_nxt = SWR_RST_DELAY;
        end
      end
      SWR_RST_DELAY: begin
        rst_clear = 1'b0;
        if (!active || !ctrl.output_good) begin
          rst_state_nxt = SWR_RST_HOLD;
        end else if (rst_count >= RESET_N - 1'b1) begin
          rst_state_nxt = SWR_RST_RUN;
        end
      end
      SWR_RST_RUN: begin
        if (!active) begin
          rst_state_nxt = SWR_RST_HOLD;
        end else if (!ctrl.output_good) begin
          rst_state_nxt = SWR_RST_DETECT;
        end
      end
      SWR_RST_DETECT: begin
        rst_clear = 1'b0;
        // a brief dip shorter than the detect delay is ignored as a glitch
        if (!active) begin
          rst_state_nxt = SWR_RST_HOLD;
        end else if (ctrl.output_good) begin
          rst_state_nxt = SWR_RST_RUN;
        end else if (rst_count >= UV_N - 1'b1) begin
          rst_state_nxt = SWR_RST_HOLD;
        end
      end
    endcase
  end

  assign reset_out_n_nxt = (rst_state_nxt == SWR_RST_RUN) ||
                           (rst_state_nxt == SWR_RST_DETECT);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rst_state_r <= SWR_RST_HOLD;
      reset_out_n_r <= 1'b0;
    end else begin
      rst_state_r <= rst_state_nxt;
      reset_out_n_r <= reset_out_n_nxt;
    end
  end

  assign reset_out_n = reset_out_n_r;

  // ********************************************************
  // watchdog
  // ********************************************************
  swr_wd_state_t wd_state_r, wd_state_nxt;
  logic [SWR_CNT_W-1:0] wd_count;
  logic wd_clear;
  logic wd_enabled;
  logic kick_any;
  logic early_fall;
  logic late;
  logic fault_n_r, fault_n_nxt;

  assign wd_enabled = active && !ctrl.watchdog_disable_in;
  // timeout mode accepts either polarity, window mode only falling edges
  assign kick_any = ctrl.timeout_mode ? (kick_edges.rise | kick_edges.fall)
                                      : kick_edges.fall;
  assign early_fall = !ctrl.timeout_mode && kick_edges.fall &&
                      (wd_count < LOWER_N);
  assign late = (wd_count >= UPPER_N - 1'b1) && !kick_any;

  swr_timer u_wd_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .clear(wd_clear),
    .count(wd_count)
  );

  always_comb begin
    wd_state_nxt = wd_state_r;
    wd_clear = 1'b1;
    unique case (wd_state_r)
      SWR_WD_IDLE: begin
        if (wd_enabled) begin
          wd_state_nxt = SWR_WD_WATCH;
        end
      end
      SWR_WD_WATCH: begin
        wd_clear = kick_any;
        if (!wd_enabled) begin
          wd_state_nxt = SWR_WD_IDLE;
        end else if (early_fall || late) begin
          wd_state_nxt = SWR_WD_FAULT;
          wd_clear = 1'b1;
        end
      end
      SWR_WD_FAULT: begin
        wd_clear = 1'b0; // kicks during the pulse are ignored
        if (!wd_enabled) begin
          wd_state_nxt = SWR_WD_IDLE;
        end else if (!reset_out_n_nxt) begin
          wd_state_nxt = SWR_WD_IDLE;
        end else if (wd_count >= RESET_N - 1'b1) begin
          wd_state_nxt = SWR_WD_WATCH;
          wd_clear = 1'b1;
        end
      end
      default: begin
        wd_state_nxt = SWR_WD_IDLE;
      end
    endcase
  end

  // watching starts only once the system is out of reset
  assign fault_n_nxt = (wd_state_nxt != SWR_WD_FAULT);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wd_state_r <= SWR_WD_IDLE;
      fault_n_r <= 1'b1;
    end else begin
      wd_state_r <= (wd_state_nxt == SWR_WD_WATCH && !reset_out_n_nxt) ?
                    SWR_WD_IDLE : wd_state_nxt;
      fault_n_r <= fault_n_nxt;
    end
  end

  assign watchdog_fault_n = fault_n_r;

endmodule

// ---- tb/swr_cpu_model.sv ----
// processor model that drives the kick line
`timescale 1ns/1ns
module swr_cpu_model (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [15:0] half_cyc,
  output logic kick
);
  // ******
  // kick generation
  // ******
  int cnt_r;
  initial kick = 1'h1;
  always @(negedge sys_clk) begin
    if (!run) begin
      cnt_r <= 0;
      kick <= 1'h1; // pulled up while idle
    end else if (cnt_r >= half_cyc - 1) begin
      cnt_r <= 0;
      kick <= ~kick;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule

// ---- tb/swr_sup_asserts.sv ----
// checker for reset and watchdog timing
`timescale 1ns/1ns
module swr_sup_asserts
  import swr_pkg::*;
#(
  parameter int UPPER_CYC = SWR_UPPER_CYC,
  parameter int RESET_CYC = SWR_RESET_CYC,
  parameter int UV_CYC = SWR_UV_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic global_enable_lockout,
  input wire logic output_good,
  input wire logic watchdog_disable_in,
  input wire logic mode_timeout,
  input wire logic kick_input,
  input wire logic reset_out_n,
  input wire logic watchdog_fault_n
);
  // ******
  // run-length counters
  // ******
  int good_r, bad_r, wlo_r, quiet_r;
  logic kick_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      good_r <= 0;
      bad_r <= 0;
      wlo_r <= 0;
      quiet_r <= 0;
      kick_r <= 1'h1;
    end else begin
      good_r <= (output_good && global_enable_lockout) ? good_r + 1 : 0;
      bad_r <= output_good ? 0 : bad_r + 1;
      wlo_r <= watchdog_fault_n ? 0 : wlo_r + 1;
      // measured from the pin, so it leads the design by the sync delay
      quiet_r <= (kick_input != kick_r || !reset_out_n || !watchdog_fault_n
        || watchdog_disable_in) ? 0 : quiet_r + 1;
      kick_r <= kick_input;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_disable_holds_high: assert property (watchdog_disable_in [*6] |-> watchdog_fault_n)
    else $error("fault while disabled");
  a_enable_holds_off: assert property (!global_enable_lockout [*6]
    |-> !reset_out_n && watchdog_fault_n) else $error("active while off");
  a_undervolt_resets: assert property (bad_r > UV_CYC + 6 |-> !reset_out_n)
    else $error("no reset on low output");
  a_release_delay: assert property ($rose(reset_out_n)
    |-> good_r >= RESET_CYC && good_r <= RESET_CYC + 8) else $error("release delay");
  a_fault_width: assert property ($rose(watchdog_fault_n) && reset_out_n
    && !watchdog_disable_in |-> wlo_r >= RESET_CYC - 1 && wlo_r <= RESET_CYC + 1)
    else $error("fault length");
  a_timeout_min: assert property ($fell(watchdog_fault_n) && mode_timeout
    |-> quiet_r >= UPPER_CYC - 2) else $error("fault too early");
  a_timeout_max: assert property (mode_timeout && global_enable_lockout
    |-> quiet_r < UPPER_CYC + 8) else $error("fault missing");
  a_reset_ends_fault: assert property (!reset_out_n && !$past(reset_out_n)
    |-> watchdog_fault_n) else $error("fault outlives reset");
  c_timeout_fault: cover property ($fell(watchdog_fault_n) && mode_timeout);
  c_window_fault: cover property ($fell(watchdog_fault_n) && !mode_timeout);
  c_release: cover property ($rose(reset_out_n));
endmodule

bind swr_supervisor swr_sup_asserts #(.UPPER_CYC(UPPER_CYC), .RESET_CYC(RESET_CYC),
  .UV_CYC(UV_CYC)) chk (.sys_clk(sys_clk), .reset(reset),
  .global_enable_lockout(global_enable_lockout), .output_good(output_good),
  .watchdog_disable_in(watchdog_disable_in), .mode_timeout(mode_timeout),
  .kick_input(kick_input), .reset_out_n(reset_out_n), .watchdog_fault_n(watchdog_fault_n));

// ---- tb/swr_supervisor_bench.sv ----
// bench for the supervisor reset and watchdog
`timescale 1ns/1ns
module swr_supervisor_bench import swr_pkg::*;;
  // ******
  // set-up
  // ******
  localparam int UP = 200;
  localparam int LO = 20;
  localparam int RS = 50;
  localparam int UV = 5;
  logic sys_clk, reset, en, good, dis, tmode, run, kick, rst_out_n, fault_n;
  logic [15:0] half;
  int error_cnt, cmp_count, n;
  always #50 sys_clk = ~sys_clk;
  swr_supervisor #(.UPPER_CYC(UP), .LOWER_CYC(LO), .RESET_CYC(RS), .UV_CYC(UV)) uut (
    .sys_clk(sys_clk), .reset(reset), .global_enable_lockout(en), .output_good(good),
    .watchdog_disable_in(dis), .mode_timeout(tmode), .kick_input(kick),
    .reset_out_n(rst_out_n), .watchdog_fault_n(fault_n));
  swr_cpu_model cpu (.sys_clk(sys_clk), .run(run), .half_cyc(half), .kick(kick));
  task automatic give_verdict();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic wait_sig(input logic wd, input logic v, input int lim);
    n = 0;
    while (((wd ? fault_n : rst_out_n) !== v) && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      $display("[FAIL] wait_out exp %b seen %b", v, wd ? fault_n : rst_out_n);
      give_verdict();
    end
  endtask
  task automatic quiet_for(input int lim);
    n = 0;
    repeat (lim) begin
      @(negedge sys_clk);
      if (fault_n !== 1'h1) n++;
    end
  endtask
  // enable low first, so every scenario starts from a clean power-up
  task automatic boot(input logic tm);
    en = 1'h0;
    run = 1'h0;
    tmode = tm;
    repeat (8) @(negedge sys_clk);
    check("rst_off", rst_out_n, 1'h0);
    check("wdo_off", fault_n, 1'h1);
    en = 1'h1;
    wait_sig(1'h0, 1'h1, RS + 20);
    check("por_delay", n >= RS && n <= RS + 8, 1'h1);
  endtask
  task automatic t_timeout_idle();
    boot(1'h1);
    wait_sig(1'h1, 1'h0, UP + 20);
    check("to_fault", n >= UP - 1 && n <= UP + 8, 1'h1);
    wait_sig(1'h1, 1'h1, RS + 20);
    check("pulse_len", n >= RS - 1 && n <= RS + 1, 1'h1);
    wait_sig(1'h1, 1'h0, UP + 20);
    check("fresh_time", n >= UP - 1 && n <= UP + 8, 1'h1);
    good = 1'h0;
    wait_sig(1'h0, 1'h0, UV + 20);
    check("uv_delay", n >= UV && n <= UV + 8, 1'h1);
    @(negedge sys_clk);
    check("fault_end", fault_n, 1'h1);
    good = 1'h1;
    wait_sig(1'h0, 1'h1, RS + 20);
    check("por_again", n >= RS && n <= RS + 8, 1'h1);
  endtask
  task automatic kick_run(input logic tm, input logic [15:0] h, input logic flt);
    boot(tm);
    half = h;
    run = 1'h1;
    quiet_for(600);
    check("kick_fault", n > 0, flt);
  endtask
  task automatic t_disabled();
    dis = 1'h1;
    boot(1'h1);
    quiet_for(3 * UP);
    check("dis_quiet", n == 0, 1'h1);
    dis = 1'h0;
  endtask
  // ******
  // sequence
  // ******
  initial begin
    sys_clk = 1'h0;
    reset = 1'h1;
    en = 1'h0;
    good = 1'h1;
    dis = 1'h0;
    tmode = 1'h1;
    run = 1'h0;
    half = 16'h0010;
    repeat (4) @(negedge sys_clk);
    reset = 1'h0;
    t_timeout_idle();
    kick_run(1'h1, 16'h0082, 1'h0);
    kick_run(1'h0, 16'h001E, 1'h0);
    kick_run(1'h0, 16'h0003, 1'h1);
    kick_run(1'h0, 16'h0082, 1'h1);
    t_disabled();
    give_verdict();
  end
endmodule
